// ==== logic/flsr_status_core.sv ====
`default_nettype none
module flsr_status_core #(
   parameter int ADDR_BYTES = 4
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic write_protect_n,
   input wire logic protect_volatility_select,
   input wire logic config_freeze,
   input wire logic arr_done,
   input wire logic arr_fail,
   input wire logic arr_fail_prot,
   input wire logic sector_prot,
   input wire logic otp_target_locked,
   input wire logic bp_region_hit,
   output logic so,
   output logic so_oe,
   output logic arr_start,
   output flsr_pkg::flsr_op_type arr_kind,
   output logic [31:0] arr_addr,
   output logic [7:0] arr_data,
   output logic arr_data_valid,
   output logic arr_suspend,
   output logic [7:0] status_reg_one
);
   if (ADDR_BYTES < 3 || ADDR_BYTES > 4) begin : g_bad_addr
      $error("ADDR_BYTES must be 3 or 4");
   end

   localparam logic [2:0] ADDR_END = 3'(ADDR_BYTES);
   localparam logic [2:0] ERASE_LEN = 3'(ADDR_BYTES + 1);

   flsr_link_if lnk ();
   logic sck_s, cs_n_s, si_s, wp_s;

   flsr_sync #(.WIDTH(4), .RST_VAL(flsr_pkg::PIN_IDLE)) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .din({sck, cs_n, si, write_protect_n}),
      .dout({sck_s, cs_n_s, si_s, wp_s})
   );

   flsr_spi_shift u_shift (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .sck_s(sck_s),
      .cs_n_s(cs_n_s),
      .si_s(si_s),
      .so(so),
      .so_oe(so_oe),
      .lnk(lnk)
   );

   flsr_pkg::flsr_op_type st_q, st_d, kind_q, kind_d;
   logic lock_q, lock_d, perr_q, perr_d, eerr_q, eerr_d, wel_q, wel_d;
   logic [2:0] bpv_q, bpv_d, bpn_q, bpn_d;
   logic [7:0] cmd_q, cmd_d, wdat_q, wdat_d, tx_q, tx_d, sr_q, sr_d;
   logic [7:0] dat_q, dat_d;
   logic [2:0] cnt_q, cnt_d;
   logic [31:0] addr_q, addr_d;
   logic start_q, start_d, datv_q, datv_d, susp_q, susp_d;
   logic [2:0] prot;
   logic busy, locked, quiet, go;
   logic [7:0] sr_now, cmd_cur;

   always_comb begin
      // nonvolatile copy survives soft reset; volatile copy does not
      prot = protect_volatility_select ? bpv_q : bpn_q;
      busy = (st_q != flsr_pkg::OPK_IDLE) || perr_q || eerr_q;
      locked = lock_q && !wp_s;
      sr_now = 8'h00;
      sr_now[flsr_pkg::LOCK_POS] = lock_q;
      sr_now[flsr_pkg::PFAIL_POS] = perr_q;
      sr_now[flsr_pkg::EFAIL_POS] = eerr_q;
      sr_now[flsr_pkg::PROT_HI_POS:flsr_pkg::PROT_LO_POS] = prot;
      sr_now[flsr_pkg::LATCH_POS] = wel_q;
      sr_now[flsr_pkg::BUSY_POS] = busy;
      quiet = (cmd_q == flsr_pkg::OP_STATUS_READ) || (cmd_q == flsr_pkg::OP_STATUS2_READ)
         || (cmd_q == flsr_pkg::OP_ERASE_SUSPEND) || (cmd_q == flsr_pkg::OP_PROGRAM_SUSPEND)
         || (cmd_q == flsr_pkg::OP_CLEAR_STATUS) || (cmd_q == flsr_pkg::OP_SOFT_RESET);
      go = lnk.frame_end && (!busy || quiet);
      st_d = st_q;
      kind_d = kind_q;
      lock_d = lock_q;
      perr_d = perr_q;
      eerr_d = eerr_q;
      wel_d = wel_q;
      bpv_d = bpv_q;
      bpn_d = bpn_q;
      cmd_d = cmd_q;
      wdat_d = wdat_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      dat_d = dat_q;
      start_d = 1'b0;
      datv_d = 1'b0;
      susp_d = 1'b0;

      if (lnk.frame_start) begin
         cnt_d = 3'h0;
         cmd_d = 8'h00;
         addr_d = 32'h0000_0000;
      end
      if (lnk.rx_valid) begin
         if (cnt_q != 3'h7) begin
            cnt_d = cnt_q + 3'h1;
         end
         if (cnt_q == 3'h0) begin
            cmd_d = lnk.rx_byte;
         end else if (cnt_q <= ADDR_END) begin
            addr_d = {addr_q[23:0], lnk.rx_byte};
         end
         if (cnt_q == 3'h1) begin
            wdat_d = lnk.rx_byte;
         end
         if (cmd_q == flsr_pkg::OP_PAGE_PROGRAM && cnt_q > ADDR_END && wel_q && !busy) begin
            dat_d = lnk.rx_byte;
            datv_d = 1'b1;
         end
      end

      if (go) begin
         case (cmd_q)
            flsr_pkg::OP_WRITE_ENABLE: begin
               if (cnt_q == 3'h1) begin
                  wel_d = 1'b1;
               end
            end
            flsr_pkg::OP_WRITE_DISABLE: begin
               if (cnt_q == 3'h1) begin
                  wel_d = 1'b0;
               end
            end
            flsr_pkg::OP_CLEAR_STATUS: begin
               perr_d = 1'b0;
               eerr_d = 1'b0;
            end
            flsr_pkg::OP_REGISTER_WRITE: begin
               // latch is left alone here; successful completion or a reset clears it
               if (cnt_q >= 3'h2 && wel_q && !locked) begin
                  lock_d = wdat_q[flsr_pkg::LOCK_POS];
                  if (!config_freeze) begin
                     if (protect_volatility_select) begin
                        bpv_d = wdat_q[flsr_pkg::PROT_HI_POS:flsr_pkg::PROT_LO_POS];
                     end else begin
                        bpn_d = wdat_q[flsr_pkg::PROT_HI_POS:flsr_pkg::PROT_LO_POS];
                     end
                  end
                  st_d = flsr_pkg::OPK_REG;
                  kind_d = flsr_pkg::OPK_REG;
                  start_d = 1'b1;
               end
            end
            flsr_pkg::OP_PAGE_PROGRAM: begin
               if (cnt_q > ADDR_END && wel_q) begin
                  if (sector_prot || otp_target_locked || bp_region_hit) begin
                     perr_d = 1'b1;
                  end else begin
                     st_d = flsr_pkg::OPK_PROG;
                     kind_d = flsr_pkg::OPK_PROG;
                     start_d = 1'b1;
                  end
               end
            end
            flsr_pkg::OP_SECTOR_ERASE: begin
               if (cnt_q == ERASE_LEN && wel_q) begin
                  if (sector_prot || bp_region_hit) begin
                     eerr_d = 1'b1;
                  end else begin
                     st_d = flsr_pkg::OPK_ERASE;
                     kind_d = flsr_pkg::OPK_ERASE;
                     start_d = 1'b1;
                  end
               end
            end
            flsr_pkg::OP_BULK_ERASE, flsr_pkg::OP_BULK_ERASE_ALT: begin
               if (cnt_q == 3'h1 && wel_q && prot == 3'h0) begin
                  st_d = flsr_pkg::OPK_BULK;
                  kind_d = flsr_pkg::OPK_BULK;
                  start_d = 1'b1;
               end
            end
            flsr_pkg::OP_ERASE_SUSPEND: begin
               susp_d = (st_q == flsr_pkg::OPK_ERASE) || (st_q == flsr_pkg::OPK_BULK);
            end
            flsr_pkg::OP_PROGRAM_SUSPEND: begin
               susp_d = (st_q == flsr_pkg::OPK_PROG);
            end
            flsr_pkg::OP_SOFT_RESET: begin
               // array side must abort on its own; no abort strobe exists
               st_d = flsr_pkg::OPK_IDLE;
               wel_d = 1'b0;
               perr_d = 1'b0;
               eerr_d = 1'b0;
               bpv_d = flsr_pkg::PROT_VOL_RST;
            end
            default: begin
            end
         endcase
      end

      // array events come last so a fail in the clear cycle still sets
      if (st_q != flsr_pkg::OPK_IDLE && arr_done) begin
         st_d = flsr_pkg::OPK_IDLE;
         if (!arr_fail) begin
            wel_d = 1'b0;
         end else if (st_q == flsr_pkg::OPK_PROG) begin
            perr_d = 1'b1;
         end else if (st_q == flsr_pkg::OPK_ERASE) begin
            eerr_d = 1'b1;
         end else if (st_q == flsr_pkg::OPK_BULK && !arr_fail_prot) begin
            eerr_d = 1'b1;
         end
      end

      cmd_cur = (lnk.rx_valid && cnt_q == 3'h0) ? lnk.rx_byte : cmd_d;
      if (cmd_cur == flsr_pkg::OP_STATUS_READ) begin
         tx_d = sr_now;
      end else begin
         tx_d = flsr_pkg::STATUS2_VALUE;
      end
      sr_d = sr_now;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= flsr_pkg::OPK_IDLE;
         kind_q <= flsr_pkg::OPK_IDLE;
         lock_q <= flsr_pkg::LOCK_RST;
         perr_q <= 1'b0;
         eerr_q <= 1'b0;
         wel_q <= 1'b0;
         bpv_q <= flsr_pkg::PROT_VOL_RST;
         bpn_q <= flsr_pkg::PROT_NV_RST;
         cmd_q <= 8'h00;
         wdat_q <= 8'h00;
         cnt_q <= 3'h0;
         addr_q <= 32'h0000_0000;
         dat_q <= 8'h00;
         tx_q <= 8'h00;
         sr_q <= 8'h00;
         start_q <= 1'b0;
         datv_q <= 1'b0;
         susp_q <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         kind_q <= kind_d;
         lock_q <= lock_d;
         perr_q <= perr_d;
         eerr_q <= eerr_d;
         wel_q <= wel_d;
         bpv_q <= bpv_d;
         bpn_q <= bpn_d;
         cmd_q <= cmd_d;
         wdat_q <= wdat_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         dat_q <= dat_d;
         tx_q <= tx_d;
         sr_q <= sr_d;
         start_q <= start_d;
         datv_q <= datv_d;
         susp_q <= susp_d;
      end
   end

   assign lnk.tx_byte = tx_q;
   assign arr_start = start_q;
   assign arr_kind = kind_q;
   assign arr_addr = addr_q;
   assign arr_data = dat_q;
   assign arr_data_valid = datv_q;
   assign arr_suspend = susp_q;
   assign status_reg_one = sr_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst || !ce);

   a_write_enable_cmd_sets_latch: assert property (go && cmd_q == flsr_pkg::OP_WRITE_ENABLE
      && cnt_q == 3'h1 |=> wel_q) else $error("write enable did not set latch");
   a_write_disable_cmd_clears_latch: assert property (go && cmd_q == flsr_pkg::OP_WRITE_DISABLE
      && cnt_q == 3'h1 && !(arr_done && st_q != flsr_pkg::OPK_IDLE) |=> !wel_q)
      else $error("write disable left latch set");
   a_lock_blocks_write: assert property (lnk.frame_end && cmd_q == flsr_pkg::OP_REGISTER_WRITE
      && locked |=> !arr_start && $stable(lock_q) && $stable(bpv_q) && $stable(bpn_q))
      else $error("locked register write took effect");
   a_start_needs_latch: assert property (arr_start |-> $past(wel_q))
      else $error("operation started without latch");
   a_bulk_needs_clear: assert property (arr_start && arr_kind == flsr_pkg::OPK_BULK
      |-> $past(prot) == 3'h0) else $error("bulk erase with range bits set");
   a_done_clears_latch: assert property (st_q != flsr_pkg::OPK_IDLE && arr_done && !arr_fail
      && !lnk.frame_end |=> !wel_q) else $error("latch kept after success");
   a_fail_flag_holds: assert property (perr_q && !(go && (cmd_q == flsr_pkg::OP_CLEAR_STATUS
      || cmd_q == flsr_pkg::OP_SOFT_RESET)) |=> perr_q)
      else $error("program fail flag dropped without clear");
   a_error_busy_status: assert property ((perr_q || eerr_q) |=> status_reg_one[0])
      else $error("busy not shown with fail flag");
   a_prog_fail_sets: assert property (st_q == flsr_pkg::OPK_PROG && arr_done && arr_fail
      |=> perr_q ##1 status_reg_one[6]) else $error("program failure not flagged");
   a_bulk_prot_quiet: assert property (st_q == flsr_pkg::OPK_BULK && arr_done && arr_fail
      && arr_fail_prot && !eerr_q |=> !eerr_q) else $error("bulk erase flagged protection");
   a_busy_ignores_write_enable_cmd: assert property (busy && lnk.frame_end
      && cmd_q == flsr_pkg::OP_WRITE_ENABLE && !arr_done |=> $stable(wel_q))
      else $error("write enable taken while busy");
   a_suspend_matches: assert property (arr_suspend |-> $past(st_q) != flsr_pkg::OPK_IDLE
      && $past(st_q) != flsr_pkg::OPK_REG) else $error("suspend without array op");

   c_write_enable_cmd: cover property (go && cmd_q == flsr_pkg::OP_WRITE_ENABLE ##[1:400] arr_start);
   c_prog_fail: cover property (st_q == flsr_pkg::OPK_PROG && arr_done && arr_fail);
   c_status_busy: cover property (busy && cmd_q == flsr_pkg::OP_STATUS_READ && lnk.rx_valid);
   c_clear_after_fail: cover property (eerr_q ##[1:800] !eerr_q);
endmodule : flsr_status_core
`default_nettype wire

// ==== logic/flsr_pkg.sv ====
// Summary of operation
// - opcodes 05h, 06h, 04h read status, set latch, clear latch.
// - opcode 01h writes status register one; 30h clears status flags.
// - lock bit set with protect pin low ignores register write completely.
// - lock clear or protect pin high lets register write change lock and range.
// - program failure, protected sector or locked otp target sets program fail flag.
// - erase failure or individually protected sector sets erase fail flag.
// - bulk erase meeting a protected sector does not set erase fail flag.
// - fail flags read-only, cleared only by clear status command or resets.
// - range bits volatile when volatility select is 1, else nonvolatile.
// - nonzero range bits block program and erase of selected region.
// - bulk erase runs only when all three range bits are zero.
// - program, erase, register write need latch set; write enable sets it.
// - write disable clears latch; later writes refused until set again.
// - successful program, write or erase completion clears latch.
// - resets clear the latch; register write leaves it set until its completion clears it.
// - while busy only status reads, suspends, clear status, soft reset.
// - suspend accepted only while matching erase or program runs.
// - a fail flag keeps busy set until clear status or a reset arrives.
// - fail flags update while busy so status reads show errors.
// - config freeze holds range bits against register write while it is high.
`default_nettype none
package flsr_pkg;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS2_READ = 8'h07;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_REGISTER_WRITE = 8'h01;
   localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
   localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
   localparam logic [7:0] OP_BULK_ERASE = 8'h60;
   localparam logic [7:0] OP_BULK_ERASE_ALT = 8'hc7;
   localparam logic [7:0] OP_ERASE_SUSPEND = 8'h75;
   localparam logic [7:0] OP_PROGRAM_SUSPEND = 8'h85;
   localparam logic [7:0] OP_SOFT_RESET = 8'hf0;
   localparam int LOCK_POS = 7;
   localparam int PFAIL_POS = 6;
   localparam int EFAIL_POS = 5;
   localparam int PROT_HI_POS = 4;
   localparam int PROT_LO_POS = 2;
   localparam int LATCH_POS = 1;
   localparam int BUSY_POS = 0;
   localparam logic [2:0] PROT_VOL_RST = 3'h7;
   localparam logic [2:0] PROT_NV_RST = 3'h0;
   localparam logic LOCK_RST = 1'b0;
   localparam logic [7:0] STATUS2_VALUE = 8'h00;
   // pins synchronised as {sck, cs_n, si, write_protect_n}, idle levels
   localparam logic [3:0] PIN_IDLE = 4'h5;
   localparam int CNT_W = 3;
   typedef enum logic [4:0] {
      OPK_IDLE = 5'h01,
      OPK_REG = 5'h02,
      OPK_PROG = 5'h04,
      OPK_ERASE = 5'h08,
      OPK_BULK = 5'h10
   } flsr_op_type;
endpackage : flsr_pkg
`default_nettype wire

// ==== logic/flsr_link_if.sv ====
`default_nettype none
interface flsr_link_if;
   logic [7:0] rx_byte;
   logic rx_valid;
   logic frame_start;
   logic frame_end;
   logic [7:0] tx_byte;
   modport shifter (output rx_byte, rx_valid, frame_start, frame_end, input tx_byte);
   modport core (input rx_byte, rx_valid, frame_start, frame_end, output tx_byte);
endinterface : flsr_link_if
`default_nettype wire

// ==== logic/flsr_sync.sv ====
`default_nettype none
module flsr_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = din;
      sync_d = meta_q;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else if (ce) begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;
endmodule : flsr_sync
`default_nettype wire

// ==== logic/flsr_spi_shift.sv ====
`default_nettype none
module flsr_spi_shift (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic sck_s,
   input wire logic cs_n_s,
   input wire logic si_s,
   output logic so,
   output logic so_oe,
   flsr_link_if.shifter lnk
);
   logic sck_d_q, sck_d_d, cs_d_q, cs_d_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] rx_q, rx_d, byte_q, byte_d;
   logic [6:0] tx_q, tx_d;
   logic so_q, so_d, oe_q, oe_d;
   logic rxv_q, rxv_d, fs_q, fs_d, fe_q, fe_d;

   always_comb begin
      sck_d_d = sck_s;
      cs_d_d = cs_n_s;
      bit_d = bit_q;
      rx_d = rx_q;
      byte_d = byte_q;
      tx_d = tx_q;
      so_d = so_q;
      oe_d = !cs_n_s;
      rxv_d = 1'b0;
      fs_d = cs_d_q && !cs_n_s;
      fe_d = !cs_d_q && cs_n_s;
      if (cs_n_s) begin
         bit_d = 3'h0;
      end else if (sck_s && !sck_d_q) begin
         // mode 0: sample on the rising edge
         rx_d = {rx_q[6:0], si_s};
         bit_d = bit_q + 3'h1;
         if (bit_q == 3'h7) begin
            rxv_d = 1'b1;
            byte_d = {rx_q[6:0], si_s};
         end
      end else if (!sck_s && sck_d_q) begin
         // a fresh byte is taken at every byte boundary, so reads repeat
         if (bit_q == 3'h0) begin
            {so_d, tx_d} = lnk.tx_byte;
         end else begin
            {so_d, tx_d} = {tx_q, 1'b0};
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sck_d_q <= 1'b0;
         cs_d_q <= 1'b1;
         bit_q <= 3'h0;
         rx_q <= 8'h00;
         byte_q <= 8'h00;
         tx_q <= 7'h00;
         so_q <= 1'b0;
         oe_q <= 1'b0;
         rxv_q <= 1'b0;
         fs_q <= 1'b0;
         fe_q <= 1'b0;
      end else if (ce) begin
         sck_d_q <= sck_d_d;
         cs_d_q <= cs_d_d;
         bit_q <= bit_d;
         rx_q <= rx_d;
         byte_q <= byte_d;
         tx_q <= tx_d;
         so_q <= so_d;
         oe_q <= oe_d;
         rxv_q <= rxv_d;
         fs_q <= fs_d;
         fe_q <= fe_d;
      end
   end

   assign so = so_q;
   assign so_oe = oe_q;
   assign lnk.rx_byte = byte_q;
   assign lnk.rx_valid = rxv_q;
   assign lnk.frame_start = fs_q;
   assign lnk.frame_end = fe_q;
endmodule : flsr_spi_shift
`default_nettype wire

// ==== verification/flsr_host_model.sv ====
`default_nettype none
module flsr_host_model (
   input wire logic mclk,
   input wire logic so,
   output logic sck,
   output logic cs_n,
   output logic si
);
   timeunit 1ns;
   timeprecision 100ps;
   // half of the 80 ns link period, in mclk cycles
   localparam int HALF = 8;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // bytes sit at the low end of tx, first byte highest; rx keeps the last 8 bits seen
   task automatic xfer(input logic [47:0] tx, input int n, output logic [7:0] rx);
      int k;
      rx = 8'h00;
      cs_n <= 1'b0;
      repeat (HALF) @(posedge mclk);
      for (k = 8 * n - 1; k >= 0; k--) begin
         si <= tx[k];
         repeat (HALF) @(posedge mclk);
         sck <= 1'b1;
         rx = {rx[6:0], so};
         repeat (HALF) @(posedge mclk);
         sck <= 1'b0;
      end
      repeat (HALF) @(posedge mclk);
      cs_n <= 1'b1;
      // a released data line must not keep showing its last bit
      si <= ~si;
      repeat (4 * HALF) @(posedge mclk);
   endtask : xfer
endmodule : flsr_host_model
`default_nettype wire

// ==== verification/testbench.sv ====
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LIMIT = 40000;
   logic mclk, nrst, ce, sck, cs_n, si, write_protect_n, pvs_sel, config_freeze;
   logic arr_done, arr_fail, arr_fail_prot, sector_prot, otp_target_locked, bp_region_hit;
   logic so, so_oe, arr_start, arr_data_valid, arr_suspend;
   flsr_pkg::flsr_op_type arr_kind;
   flsr_pkg::flsr_op_type kind_seen;
   logic [31:0] arr_addr;
   logic [7:0] arr_data;
   logic [7:0] status_reg_one;
   int error_cnt, cmp_count, cyc, dly, op_len;
   logic [31:0] addr_seen;
   logic [7:0] data_seen, susp_cnt, rd;
   logic oe_seen;

   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;

   flsr_host_model host_u (.mclk(mclk), .so(so), .sck(sck), .cs_n(cs_n), .si(si));

   flsr_status_core dut_u (
      .mclk(mclk), .nrst(nrst), .ce(ce), .sck(sck), .cs_n(cs_n), .si(si),
      .write_protect_n(write_protect_n), .protect_volatility_select(pvs_sel),
      .config_freeze(config_freeze), .arr_done(arr_done), .arr_fail(arr_fail),
      .arr_fail_prot(arr_fail_prot), .sector_prot(sector_prot),
      .otp_target_locked(otp_target_locked), .bp_region_hit(bp_region_hit),
      .so(so), .so_oe(so_oe), .arr_start(arr_start), .arr_kind(arr_kind),
      .arr_addr(arr_addr), .arr_data(arr_data), .arr_data_valid(arr_data_valid),
      .arr_suspend(arr_suspend), .status_reg_one(status_reg_one)
   );

   // array engine stand-in: every started operation ends op_len cycles later
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      arr_done <= 1'b0;
      if (so_oe === 1'b1) begin
         oe_seen <= 1'b1;
      end
      if (arr_data_valid === 1'b1) begin
         data_seen <= arr_data;
      end
      if (arr_suspend === 1'b1) begin
         susp_cnt <= susp_cnt + 8'h01;
      end
      if (arr_start === 1'b1) begin
         dly <= op_len;
         kind_seen <= arr_kind;
         addr_seen <= arr_addr;
      end else if (dly == 1) begin
         arr_done <= 1'b1;
         dly <= 0;
      end else if (dly != 0) begin
         dly <= dly - 1;
      end
      if (cyc == LIMIT) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
      cmp_count++;
      if ((got & msk) !== (exp & msk)) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_word

   // long settle covers the 20-cycle array operation started at frame end
   task automatic cmd(input logic [47:0] d, input int n);
      logic [7:0] r;
      host_u.xfer(d, n, r);
      repeat (60) @(posedge mclk);
   endtask : cmd

   task automatic check_sr(input logic [7:0] exp, input logic [7:0] msk);
      logic [7:0] r;
      host_u.xfer(48'h0500, 2, r);
      check_val(r, exp, msk);
   endtask : check_sr

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      write_protect_n = 1'b1;
      pvs_sel = 1'b1;
      config_freeze = 1'b0;
      arr_done = 1'b0;
      arr_fail = 1'b0;
      arr_fail_prot = 1'b0;
      sector_prot = 1'b0;
      otp_target_locked = 1'b0;
      bp_region_hit = 1'b0;
      kind_seen = flsr_pkg::OPK_IDLE;
      error_cnt = 0;
      cmp_count = 0;
      cyc = 0;
      dly = 0;
      op_len = 20;
      addr_seen = 32'h0000_0000;
      data_seen = 8'h00;
      susp_cnt = 8'h00;
      oe_seen = 1'b0;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      check_sr(8'h1c, 8'hff);
      check_val(status_reg_one, 8'h1c, 8'hff);
      check_val({7'h00, oe_seen}, 8'h01, 8'hff);
      check_val({7'h00, so_oe}, 8'h00, 8'hff);
      cmd(48'h06, 1);
      check_sr(8'h1e, 8'hff);
      cmd(48'h04, 1);
      check_sr(8'h1c, 8'hff);
      cmd(48'h0100, 2);
      check_sr(8'h1c, 8'hff);
      cmd(48'h06, 1);
      cmd(48'h01e3, 2);
      check_sr(8'h80, 8'hff);
      write_protect_n <= 1'b0;
      cmd(48'h06, 1);
      cmd(48'h0100, 2);
      check_sr(8'h82, 8'hff);
      write_protect_n <= 1'b1;
      cmd(48'h0100, 2);
      check_sr(8'h00, 8'hff);
      config_freeze <= 1'b1;
      cmd(48'h06, 1);
      cmd(48'h011c, 2);
      check_sr(8'h00, 8'hff);
      config_freeze <= 1'b0;
      arr_fail <= 1'b1;
      cmd(48'h06, 1);
      cmd(48'h02_0012_3456_a5, 6);
      check_val({3'h0, kind_seen}, {3'h0, flsr_pkg::OPK_PROG}, 8'hff);
      check_word(addr_seen, 32'h0012_3456);
      check_val(data_seen, 8'ha5, 8'hff);
      check_sr(8'h43, 8'hff);
      cmd(48'h04, 1);
      check_sr(8'h43, 8'hff);
      arr_fail <= 1'b0;
      cmd(48'h30, 1);
      check_sr(8'h02, 8'hff);
      cmd(48'h04, 1);
      check_sr(8'h00, 8'hff);
      sector_prot <= 1'b1;
      cmd(48'h06, 1);
      cmd(48'hd8_0000_0000, 5);
      check_sr(8'h23, 8'hff);
      sector_prot <= 1'b0;
      cmd(48'h30, 1);
      cmd(48'h04, 1);
      cmd(48'h06, 1);
      cmd(48'h0104, 2);
      check_sr(8'h04, 8'hff);
      cmd(48'h06, 1);
      cmd(48'h60, 1);
      check_val({3'h0, kind_seen}, {3'h0, flsr_pkg::OPK_REG}, 8'hff);
      check_sr(8'h06, 8'hff);
      cmd(48'h0100, 2);
      arr_fail <= 1'b1;
      arr_fail_prot <= 1'b1;
      cmd(48'h06, 1);
      cmd(48'hc7, 1);
      check_val({3'h0, kind_seen}, {3'h0, flsr_pkg::OPK_BULK}, 8'hff);
      check_sr(8'h00, 8'h21);
      arr_fail <= 1'b0;
      arr_fail_prot <= 1'b0;
      host_u.xfer(48'h05_0000, 3, rd);
      check_val(rd, 8'h02, 8'hff);
      // hardware reset in mid-run must drop the latch left by the failed bulk erase
      nrst <= 1'b0;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      check_sr(8'h1c, 8'hff);
      check_val(status_reg_one, 8'h1c, 8'hff);
      pvs_sel <= 1'b0;
      check_sr(8'h00, 8'hff);
      cmd(48'h06, 1);
      cmd(48'h0108, 2);
      check_sr(8'h08, 8'hff);
      pvs_sel <= 1'b1;
      check_sr(8'h1c, 8'hff);
      // long erase so that suspends and busy reads land inside it
      op_len <= 2000;
      cmd(48'h06, 1);
      cmd(48'hd8_0000_0000, 5);
      cmd(48'h85, 1);
      cmd(48'h75, 1);
      check_val(susp_cnt, 8'h01, 8'hff);
      host_u.xfer(48'h0700, 2, rd);
      check_val(rd, flsr_pkg::STATUS2_VALUE, 8'hff);
      check_sr(8'h1f, 8'hff);
      op_len <= 20;
      cmd(48'hf0, 1);
      check_sr(8'h1c, 8'hff);
      pvs_sel <= 1'b0;
      check_sr(8'h08, 8'hff);
      pvs_sel <= 1'b1;
      otp_target_locked <= 1'b1;
      cmd(48'h06, 1);
      cmd(48'h02_0000_0000_5a, 6);
      check_sr(8'h5f, 8'hff);
      check_val({3'h0, kind_seen}, {3'h0, flsr_pkg::OPK_ERASE}, 8'hff);
      otp_target_locked <= 1'b0;
      cmd(48'h30, 1);
      cmd(48'h04, 1);
      bp_region_hit <= 1'b1;
      cmd(48'h06, 1);
      cmd(48'hd8_0000_0000, 5);
      check_sr(8'h3f, 8'hff);
      bp_region_hit <= 1'b0;
      cmd(48'h30, 1);
      check_sr(8'h1e, 8'hff);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
